// ### pabd_pkg.sv
// Constants, types and decode helpers for the management address and command decoder
//
// How it works
// RQ1: Index scheme address equals twenty-five times high index plus low index.
// RQ2: Each strap level resolves to one of indices zero through twenty-four.
// RQ3: Board keeps high index zero to four; any low index, 125 addresses. Code only flags sums above 127, so 125-127 are accepted.
// RQ4: Without a high strap input, the high index is fixed at four.
// RQ5: Three-level scheme address is 20h plus three times high plus low.
// RQ6: Strap at reference reads low, floating reads open, driven high reads high.
// RQ7: Without a high strap input, three-level scheme treats it as open.
// RQ8: Address 4Bh is production only; never the operating address, never answered.
// RQ9: Board avoids SMBus reserved addresses such as 0, 12, 97, 120-123.
// RQ10: Both ends follow standard SMBus protocol; host tolerates clock stretching.
// RQ11: Status never shows busy; host must leave enough idle time instead.
// RQ12: Host leaves SMBus bus-free time between every stop and next start.
// RQ13: Host waits extra 100 ms after a non-volatile store command.
// RQ14: Only implemented command codes decode; 00h, 10h, 5Fh and others do not.
// RQ15: Status commands 78h-7Eh, 80h are read-only; clear-faults 03h accepted.
// RQ16: Monitors 88h, 8Bh-8Dh, 94h, 95h read-only; 8Eh, 90h absent.
// RQ17: Bus clock stays between 10 kHz and 100 kHz.
// RQ18: Alert output asserts whenever any fault or warning condition occurs.
// RQ19: Unimplemented command sets communication fault and changes no configuration.
// RQ20: Acknowledge only own strapped address, plus SMBus-required alert response.
package pabd_pkg;
    localparam int         IDX_W            = 5;
    localparam int         LVL_W            = 8;
    localparam int         IDX_COUNT        = 24;
    localparam logic [4:0] IDX_MAX          = 5'h18;
    localparam logic [9:0] IDX_RADIX        = 10'h019;
    localparam logic [4:0] HIGH_IDX_FIXED   = 5'h04;
    localparam logic [7:0] LVL_STEP         = 8'h0a;
    localparam logic [7:0] LVL_OFS          = 8'h05;
    localparam logic [6:0] TRI_BASE         = 7'h20;
    localparam logic [6:0] TRI_RADIX        = 7'h03;
    localparam logic [6:0] ADDR_PRODUCTION  = 7'h4b;
    localparam logic [6:0] ADDR_GEN_CALL    = 7'h00;
    localparam logic [6:0] ADDR_ALERT_RESP  = 7'h0c;
    localparam logic [6:0] ADDR_DEV_DEFAULT = 7'h61;
    localparam logic [6:0] ADDR_TEN_BIT_LO  = 7'h78;
    localparam logic [6:0] ADDR_TEN_BIT_HI  = 7'h7b;
    localparam logic [9:0] ADDR_LIMIT       = 10'h07f;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam int         STAT_BUSY_BIT    = 7;
    localparam int         STAT_CML_BIT     = 1;
    localparam int         STAT_FAULT_BIT   = 0;
    localparam int         FAULT_W          = 8;

    typedef enum logic [2:0] {
        STRAP_LOW  = 3'b001,
        STRAP_OPEN = 3'b010,
        STRAP_HIGH = 3'b100
    } pabd_strap_e;

    typedef enum logic [1:0] {
        PH_SAMPLE = 2'b01,
        PH_RUN    = 2'b10
    } pabd_phase_e;

    // One strap pin as seen by the analog front end
    typedef struct packed {
        logic [7:0] level;
        logic       at_strap_reference_node;
        logic       driven_high;
    } pabd_strap_s;

    typedef struct packed {
        logic [7:0] code;
        logic       write;
    } pabd_cmd_s;

    // Implemented command set
    function automatic logic pabd_cmd_impl(input logic [7:0] c);
        return c inside {8'h01, 8'h02, 8'h03, 8'h11, 8'h12, 8'h15, 8'h16,
            [8'h20:8'h28], 8'h32, 8'h33, 8'h37, 8'h38, 8'h39, 8'h40, 8'h41,
            8'h44, 8'h45, 8'h46, 8'h4b, 8'h4f, 8'h50, [8'h51:8'h5a], 8'h5e,
            8'h60, 8'h61, 8'h64, 8'h65, [8'h78:8'h7e], 8'h80, 8'h88,
            [8'h8b:8'h8d], 8'h94, 8'h95, [8'h98:8'h9e], 8'hb0, 8'hbe, 8'hbf,
            [8'hd0:8'hd8], [8'hdc:8'hde], [8'he0:8'he2], [8'he4:8'hea],
            8'hf0, 8'hf2, 8'hf3, [8'hfa:8'hfd]};
    endfunction

    // Read-only commands: mode, status and monitors
    function automatic logic pabd_cmd_ro(input logic [7:0] c);
        return c inside {8'h20, [8'h78:8'h7e], 8'h80, 8'h88, [8'h8b:8'h8d],
            8'h94, 8'h95};
    endfunction

    function automatic logic pabd_addr_reserved(input logic [6:0] a);
        return (a == ADDR_GEN_CALL) || (a == ADDR_ALERT_RESP) ||
               (a == ADDR_DEV_DEFAULT) ||
               ((a >= ADDR_TEN_BIT_LO) && (a <= ADDR_TEN_BIT_HI));
    endfunction

    function automatic logic [6:0] pabd_strap_val(input pabd_strap_e s);
        logic [6:0] v;
        v = 7'h01;
        unique case (s)
            STRAP_LOW:  v = 7'h00;
            STRAP_OPEN: v = 7'h01;
            STRAP_HIGH: v = 7'h02;
        endcase
        return v;
    endfunction
endpackage

// ### pabd_top.sv
// Strap address resolution, address match and command decode for the management port
`timescale 1ns/1ps
module pabd_top #(
    parameter bit HAS_HIGH_STRAP = 1'b1
) (
    input  wire logic                          mclk,
    input  wire logic                          reset,
    input  wire logic                          addr_scheme_tri,
    input  wire pabd_pkg::pabd_strap_s         addr_strap_low_digit,
    input  wire pabd_pkg::pabd_strap_s         addr_strap_high_digit,
    input  wire logic                          rx_addr_valid,
    input  wire logic [6:0]                    rx_addr,
    input  wire logic                          cmd_valid,
    input  wire pabd_pkg::pabd_cmd_s           cmd,
    input  wire logic [pabd_pkg::FAULT_W-1:0]  fault_event,
    output logic [6:0]                         bus_addr,
    output logic                               addr_config_error,
    output logic                               addr_ack,
    output logic                               cmd_accept,
    output logic                               cmd_reject,
    output logic                               cfg_write_en,
    output logic                               comm_fault,
    output logic [7:0]                         status_byte,
    output logic                               fault_alert_output_n
);
    import pabd_pkg::*;

    pabd_phase_e        phase;
    pabd_phase_e        next_phase;
    logic [4:0]         lo_idx;
    logic [4:0]         hi_idx;
    logic [4:0]         next_lo_idx;
    logic [4:0]         next_hi_idx;
    pabd_strap_e        lo_state;
    pabd_strap_e        hi_state;
    pabd_strap_e        next_lo_state;
    pabd_strap_e        next_hi_state;
    logic               tri_mode;
    logic               next_tri_mode;
    logic [6:0]         next_bus_addr;
    logic               next_addr_config_error;
    logic               next_addr_ack;
    logic               next_cmd_accept;
    logic               next_cmd_reject;
    logic               next_cfg_write_en;
    logic               next_comm_fault;
    logic [7:0]         next_status_byte;
    logic               next_fault_alert_output_n;
    logic [FAULT_W-1:0] fault_status;
    logic [FAULT_W-1:0] next_fault_status;
    logic [1:0][IDX_COUNT-1:0] above;
    logic [4:0]         cur_idx [2];
    pabd_strap_e        cur_lo_state;
    pabd_strap_e        cur_hi_state;
    logic [9:0]         idx_sum;
    logic [6:0]         tri_addr;

    // Threshold ladder per strap, one comparator per index boundary
    for (genvar s = 0; s < 2; s++) begin : g_strap
        for (genvar k = 0; k < IDX_COUNT; k++) begin : g_step
            if (s == 0) begin : g_lo
                assign above[s][k] = addr_strap_low_digit.level >=
                                     (LVL_OFS + 8'(k) * LVL_STEP); // RQ2
            end else begin : g_hi
                assign above[s][k] = addr_strap_high_digit.level >=
                                     (LVL_OFS + 8'(k) * LVL_STEP); // RQ2
            end
        end
    end

    // Thermometer count gives the index; saturates at 24 by construction
    always_comb
    begin
        for (int s = 0; s < 2; s++)
        begin
            cur_idx[s] = 5'h00;
            for (int k = 0; k < IDX_COUNT; k++)
            begin
                cur_idx[s] = cur_idx[s] + {4'h0, above[s][k]}; // RQ2
            end
        end
    end

    // Reference wins over a high reading, so a shorted strap is never high
    always_comb
    begin
        cur_lo_state = addr_strap_low_digit.at_strap_reference_node ? STRAP_LOW :
                       addr_strap_low_digit.driven_high ? STRAP_HIGH : STRAP_OPEN; // RQ6
        cur_hi_state = addr_strap_high_digit.at_strap_reference_node ? STRAP_LOW :
                       addr_strap_high_digit.driven_high ? STRAP_HIGH : STRAP_OPEN; // RQ6
        if (!HAS_HIGH_STRAP)
        begin
            cur_hi_state = STRAP_OPEN; // RQ7
        end
    end

    // Both address forms from the fresh strap readings
    always_comb
    begin
        idx_sum  = 10'(IDX_RADIX * {5'h00, (HAS_HIGH_STRAP ? cur_idx[1] : HIGH_IDX_FIXED)})
                   + {5'h00, cur_idx[0]}; // RQ1 RQ4
        tri_addr = TRI_BASE + 7'(TRI_RADIX * pabd_strap_val(cur_hi_state))
                   + pabd_strap_val(cur_lo_state); // RQ5
    end

    // Straps caught once after reset release; later pin wiggles are ignored
    always_comb
    begin
        next_phase             = phase;
        next_lo_idx            = lo_idx;
        next_hi_idx            = hi_idx;
        next_lo_state          = lo_state;
        next_hi_state          = hi_state;
        next_tri_mode          = tri_mode;
        next_bus_addr          = bus_addr;
        next_addr_config_error = addr_config_error;
        unique case (phase)
            PH_SAMPLE:
            begin
                next_phase    = PH_RUN;
                next_lo_idx   = cur_idx[0];
                next_hi_idx   = HAS_HIGH_STRAP ? cur_idx[1] : HIGH_IDX_FIXED; // RQ4
                next_lo_state = cur_lo_state;
                next_hi_state = cur_hi_state;
                next_tri_mode = addr_scheme_tri;
                if (addr_scheme_tri)
                begin
                    next_bus_addr          = tri_addr; // RQ5
                    next_addr_config_error = (cur_lo_state == STRAP_HIGH) &&
                                             (cur_hi_state == STRAP_HIGH); // RQ5
                end
                else
                begin
                    next_bus_addr          = idx_sum[6:0]; // RQ1
                    next_addr_config_error = idx_sum > ADDR_LIMIT; // RQ3
                end
                // Refusing a bad strap beats colliding with reserved traffic
                if ((next_bus_addr == ADDR_PRODUCTION) ||
                    pabd_addr_reserved(next_bus_addr))
                begin
                    next_addr_config_error = 1'b1; // RQ8 RQ9
                end
            end
            PH_RUN:
            begin
                next_phase = PH_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            phase             <= PH_SAMPLE;
            lo_idx            <= 5'h00;
            hi_idx            <= 5'h00;
            lo_state          <= STRAP_OPEN;
            hi_state          <= STRAP_OPEN;
            tri_mode          <= 1'b0;
            bus_addr          <= 7'h00;
            addr_config_error <= 1'b0;
        end
        else
        begin
            phase             <= next_phase;
            lo_idx            <= next_lo_idx;
            hi_idx            <= next_hi_idx;
            lo_state          <= next_lo_state;
            hi_state          <= next_hi_state;
            tri_mode          <= next_tri_mode;
            bus_addr          <= next_bus_addr;
            addr_config_error <= next_addr_config_error;
        end
    end

    // Address match plus alert response while an alert is pending
    always_comb
    begin
        next_addr_ack = 1'b0;
        if (rx_addr_valid && (phase == PH_RUN))
        begin
            next_addr_ack = (!addr_config_error && (rx_addr == bus_addr) &&
                             (rx_addr != ADDR_PRODUCTION)) ||
                            ((rx_addr == ADDR_ALERT_RESP) && !fault_alert_output_n); // RQ8 RQ20 RQ10
        end
    end

    // Command decode, sticky faults and status; a set beats a same-cycle clear
    always_comb
    begin
        logic clear_req;
        logic cml_set;
        clear_req         = 1'b0;
        cml_set           = 1'b0;
        next_cmd_accept   = 1'b0;
        next_cmd_reject   = 1'b0;
        next_cfg_write_en = 1'b0;
        if (cmd_valid && (phase == PH_RUN))
        begin
            if (!pabd_cmd_impl(cmd.code) || (cmd.write && pabd_cmd_ro(cmd.code)))
            begin
                next_cmd_reject = 1'b1; // RQ14 RQ15 RQ16 RQ19
                cml_set         = 1'b1; // RQ19
            end
            else
            begin
                next_cmd_accept   = 1'b1;
                clear_req         = cmd.code == CMD_CLEAR_FAULTS; // RQ15
                next_cfg_write_en = cmd.write && !clear_req;
            end
        end
        next_comm_fault   = cml_set | (comm_fault & ~clear_req);
        next_fault_status = fault_event | (fault_status & ~{FAULT_W{clear_req}});
        // Busy is never reported; host pacing covers slow internal work
        next_status_byte                 = 8'h00; // RQ11
        next_status_byte[STAT_CML_BIT]   = next_comm_fault;
        next_status_byte[STAT_FAULT_BIT] = |next_fault_status;
        next_fault_alert_output_n        = !((|next_fault_status) | next_comm_fault); // RQ18
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            addr_ack             <= 1'b0;
            cmd_accept           <= 1'b0;
            cmd_reject           <= 1'b0;
            cfg_write_en         <= 1'b0;
            comm_fault           <= 1'b0;
            fault_status         <= '0;
            status_byte          <= 8'h00;
            fault_alert_output_n <= 1'b1;
        end
        else
        begin
            addr_ack             <= next_addr_ack;
            cmd_accept           <= next_cmd_accept;
            cmd_reject           <= next_cmd_reject;
            cfg_write_en         <= next_cfg_write_en;
            comm_fault           <= next_comm_fault;
            fault_status         <= next_fault_status;
            status_byte          <= next_status_byte;
            fault_alert_output_n <= next_fault_alert_output_n;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence seq_bad_cmd;
        cmd_valid && (phase == PH_RUN) && !pabd_cmd_impl(cmd.code);
    endsequence

    sequence seq_fault_flagged;
        comm_fault && cmd_reject && !cfg_write_en && !cmd_accept;
    endsequence

    chk_index_addr: assert property ((phase == PH_RUN) && !tri_mode && !addr_config_error |->
        {3'h0, bus_addr} == 10'(IDX_RADIX * {5'h00, hi_idx}) + {5'h00, lo_idx}) // RQ1
        else $error("index address mismatch");
    chk_index_range: assert property ((phase == PH_RUN) |-> (lo_idx <= IDX_MAX) &&
        (hi_idx <= IDX_MAX)) // RQ2
        else $error("strap index out of range");
    chk_fixed_high: assert property ((phase == PH_RUN) |->
        (HAS_HIGH_STRAP || (hi_idx == HIGH_IDX_FIXED))) // RQ4
        else $error("fixed high index wrong");
    chk_tri_addr: assert property ((phase == PH_RUN) && tri_mode && !addr_config_error |->
        bus_addr == TRI_BASE + 7'(TRI_RADIX * pabd_strap_val(hi_state))
                    + pabd_strap_val(lo_state)) // RQ5
        else $error("three-level address mismatch");
    // Reset falls by a non-blocking write at an edge, so disable iff alone misses that edge
    chk_tri_class: assert property (!reset && (phase == PH_SAMPLE) &&
        addr_strap_low_digit.at_strap_reference_node |=> lo_state == STRAP_LOW) // RQ6
        else $error("strap at reference not low");
    chk_absent_open: assert property ((phase == PH_RUN) |->
        (HAS_HIGH_STRAP || (hi_state == STRAP_OPEN))) // RQ7
        else $error("absent high strap not open");
    chk_prod_addr: assert property (addr_ack |-> $past(rx_addr) != ADDR_PRODUCTION) // RQ8
        else $error("production address answered");
    chk_no_busy: assert property (!status_byte[STAT_BUSY_BIT]) // RQ11
        else $error("busy reported");
    chk_unimpl_fault: assert property (seq_bad_cmd |=> seq_fault_flagged) // RQ19 RQ14
        else $error("unimplemented command not faulted");
    chk_status_ro: assert property (cmd_valid && (phase == PH_RUN) && cmd.write &&
        pabd_cmd_ro(cmd.code) |=> cmd_reject && !cfg_write_en) // RQ15 RQ16
        else $error("write to read-only command taken");
    chk_alert_raise: assert property ((fault_event != '0) |=>
        !fault_alert_output_n && status_byte[STAT_FAULT_BIT]) // RQ18
        else $error("alert not raised on fault");
    chk_ack_match: assert property (rx_addr_valid && (phase == PH_RUN) &&
        !addr_config_error && (rx_addr == bus_addr) |=> addr_ack) // RQ20
        else $error("own address not acknowledged");
    chk_ack_foreign: assert property (rx_addr_valid && (rx_addr != bus_addr) &&
        (rx_addr != ADDR_ALERT_RESP) |=> !addr_ack) // RQ20
        else $error("foreign address acknowledged");
endmodule

// ### pabd_host_model.sv
// Host controller model that feeds address and command bytes to the decoder
`timescale 1ns/1ps
module pabd_host_model #(
    parameter int BUS_FREE  = 4,
    parameter int STORE_GAP = 4000000
) (
    input  wire logic                mclk,
    input  wire logic                reset,
    input  wire logic                go,
    input  wire logic [6:0]          t_addr,
    input  wire pabd_pkg::pabd_cmd_s t_cmd,
    output logic                     ready,
    output logic                     rx_addr_valid,
    output logic [6:0]               rx_addr,
    output logic                     cmd_valid,
    output pabd_pkg::pabd_cmd_s      cmd
);
    import pabd_pkg::*;
    int        gap = 0;
    logic      pend = 1'b0;
    pabd_cmd_s held;
    // Quiet bus at time zero
    initial
    begin
        rx_addr_valid = 1'b0;
        cmd_valid     = 1'b0;
        rx_addr       = 7'h00;
        cmd           = '0;
    end
    // Idle only once the bus-free time has run out
    assign ready = !reset && (gap == 0) && !pend;
    // Address byte, command byte next cycle, then the gap the device relies on
    always @(posedge mclk)
    begin
        rx_addr_valid <= 1'b0;
        cmd_valid     <= 1'b0;
        rx_addr       <= ~rx_addr; // Released lines never keep the last value
        cmd           <= ~cmd;
        if (reset)
        begin
            gap  <= 0;
            pend <= 1'b0;
        end
        else if (pend)
        begin
            cmd_valid <= 1'b1;
            cmd       <= held;
            pend      <= 1'b0;
            gap       <= (held.code inside {8'h11, 8'h15}) ? STORE_GAP : BUS_FREE;
        end
        else if (gap > 0)
            gap <= gap - 1;
        else if (go)
        begin
            rx_addr_valid <= 1'b1;
            rx_addr       <= t_addr;
            held          <= t_cmd;
            pend          <= 1'b1;
        end
    end
endmodule

// ### test_pmbus_address_and_command_decode.sv
// Self-checking bench for strap address resolution and command decode
`timescale 1ns/1ps
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %0t %s", $time, m); end end
module test_pmbus_address_and_command_decode;
    import pabd_pkg::*;
    logic               mclk = 1'b0;
    logic               reset = 1'b1;
    logic               addr_scheme_tri = 1'b0;
    pabd_strap_s        s_lo = '0;
    pabd_strap_s        s_hi = '0;
    logic [FAULT_W-1:0] fault_event = '0;
    logic               go = 1'b0;
    logic [6:0]         t_addr = 7'h00;
    pabd_cmd_s          t_cmd = '0;
    logic               ready, rx_addr_valid, cmd_valid, addr_ack, cmd_accept, cmd_reject;
    logic               cfg_write_en, comm_fault, fault_alert_output_n, cfg_err, cfg_err2;
    logic [6:0]         rx_addr, bus_addr, bus_addr2, e_addr, e2_addr, a;
    logic [7:0]         status_byte;
    pabd_cmd_s          cmd;
    logic               e_err, e2_err, e_ack, e_acc, e_rej, e_we, e_comm, e_flt, rej, clr;
    logic               started = 1'b0;
    int                 seed = 57;
    int                 mismatches = 0;
    int                 tests_run = 0;
    int                 cycles = 0;
    int                 e_cnt, cfg, i, hl, ll;
    int                 hl_c[4] = '{30, 240, 0, 40};
    int                 ll_c[4] = '{0, 240, 120, 200};
    logic [7:0]         codes[11] = '{8'h00, 8'h10, 8'h5f, 8'h8e, 8'h90, 8'h03, 8'h20, 8'h78,
                                      8'h21, 8'h11, 8'h03};

    // Host stands in for the bus; store wait shortened to keep the run brief
    pabd_host_model #(.BUS_FREE(4), .STORE_GAP(50)) host (
        .mclk(mclk), .reset(reset), .go(go), .t_addr(t_addr), .t_cmd(t_cmd), .ready(ready),
        .rx_addr_valid(rx_addr_valid), .rx_addr(rx_addr), .cmd_valid(cmd_valid), .cmd(cmd));
    pabd_top dut (
        .mclk(mclk), .reset(reset), .addr_scheme_tri(addr_scheme_tri),
        .addr_strap_low_digit(s_lo), .addr_strap_high_digit(s_hi),
        .rx_addr_valid(rx_addr_valid), .rx_addr(rx_addr), .cmd_valid(cmd_valid), .cmd(cmd),
        .fault_event(fault_event), .bus_addr(bus_addr), .addr_config_error(cfg_err),
        .addr_ack(addr_ack), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
        .cfg_write_en(cfg_write_en), .comm_fault(comm_fault), .status_byte(status_byte),
        .fault_alert_output_n(fault_alert_output_n));
    // Variant without a high strap input, same stimulus
    pabd_top #(.HAS_HIGH_STRAP(1'b0)) dut_fixed_high (
        .mclk(mclk), .reset(reset), .addr_scheme_tri(addr_scheme_tri),
        .addr_strap_low_digit(s_lo), .addr_strap_high_digit(s_hi),
        .rx_addr_valid(rx_addr_valid), .rx_addr(rx_addr), .cmd_valid(cmd_valid), .cmd(cmd),
        .fault_event(fault_event), .bus_addr(bus_addr2), .addr_config_error(cfg_err2),
        .addr_ack(), .cmd_accept(), .cmd_reject(), .cfg_write_en(), .comm_fault(),
        .status_byte(), .fault_alert_output_n());

    initial
    begin
        forever #12.5 mclk = ~mclk;
    end

    function automatic int lvl_idx(input logic [7:0] l);
        int n;
        n = 0;
        for (int k = 0; k < 24; k++)
            if (l >= 8'(5 + 10 * k)) n++;
        return n;
    endfunction

    function automatic int cls(input pabd_strap_s s);
        return s.at_strap_reference_node ? 0 : (s.driven_high ? 2 : 1);
    endfunction

    // Error flag and address, as the straps should resolve
    function automatic logic [7:0] calc(input logic t, input pabd_strap_s lo,
                                        input pabd_strap_s hi, input bit has_hi);
        int r;
        if (t)
            r = 32 + 3 * (has_hi ? cls(hi) : 1) + cls(lo);
        else
            r = 25 * (has_hi ? lvl_idx(hi.level) : 4) + lvl_idx(lo.level);
        return {(t && r == 40) || r > 127 ||
                r inside {0, 12, 75, 97, [120:123]}, r[6:0]};
    endfunction

    function automatic bit impl(input logic [7:0] c);
        return c inside {[8'h01:8'h03], 8'h11, 8'h12, 8'h15, 8'h16, [8'h20:8'h28], 8'h32, 8'h33,
            [8'h37:8'h39], 8'h40, 8'h41, [8'h44:8'h46], 8'h4b, [8'h4f:8'h5a], 8'h5e, 8'h60,
            8'h61, 8'h64, 8'h65, [8'h78:8'h7e], 8'h80, 8'h88, [8'h8b:8'h8d], 8'h94, 8'h95,
            [8'h98:8'h9e], 8'hb0, 8'hbe, 8'hbf, [8'hd0:8'hd8], [8'hdc:8'hde], [8'he0:8'he2],
            [8'he4:8'hea], 8'hf0, 8'hf2, 8'hf3, [8'hfa:8'hfd]};
    endfunction

    function automatic bit ro(input logic [7:0] c);
        return c inside {8'h20, [8'h78:8'h7e], 8'h80, 8'h88, [8'h8b:8'h8d], 8'h94, 8'h95};
    endfunction

    function automatic pabd_strap_s mk(input int lvl, input int c);
        return '{lvl[7:0], c == 0, c == 2};
    endfunction

    task automatic end_of_test();
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hand one transaction to the host and hold it until taken
    task automatic xfer(input logic [6:0] ad, input logic [7:0] c, input logic w);
        int n;
        @(posedge mclk);
        go <= 1'b1;
        t_addr <= ad;
        t_cmd <= '{c, w};
        for (n = 0; n < 100; n++)
        begin
            @(posedge mclk);
            if (ready === 1'b1) break;
        end
        // A host that never frees up counts against the run
        if (n == 100) mismatches++;
        go <= 1'b0;
    endtask

    // Reference model, fed with the values the design samples at this edge
    always @(posedge mclk)
    begin
        started = 1'b1;
        {e_ack, e_acc, e_rej, e_we} = 4'h0;
        rej = !impl(cmd.code) || (cmd.write && ro(cmd.code));
        clr = cmd_valid && !rej && cmd.code == CMD_CLEAR_FAULTS;
        if (reset)
        begin
            e_cnt = 0;
            {e_addr, e2_addr, e_err, e2_err, e_comm, e_flt} = '0;
        end
        else if (e_cnt == 0)
        begin
            {e_err, e_addr} = calc(addr_scheme_tri, s_lo, s_hi, 1'b1);
            {e2_err, e2_addr} = calc(addr_scheme_tri, s_lo, s_hi, 1'b0);
            e_cnt = 1;
        end
        else
        begin
            e_ack = rx_addr_valid && ((!e_err && rx_addr == e_addr) ||
                    (rx_addr == ADDR_ALERT_RESP && (e_comm || e_flt)));
            e_acc = cmd_valid && !rej;
            e_rej = cmd_valid && rej;
            e_we = e_acc && cmd.write && cmd.code != CMD_CLEAR_FAULTS;
            e_comm = e_rej || (e_comm && !clr);
            e_flt = (|fault_event) || (e_flt && !clr);
        end
    end

    // Outputs have settled by the falling edge
    always @(negedge mclk)
        if (started)
        begin
            `CHK(addr_ack, e_ack, "address acknowledge")
            `CHK(cmd_accept, e_acc, "command accept")
            `CHK(cmd_reject, e_rej, "command reject")
            `CHK(cfg_write_en, e_we, "configuration write")
            `CHK(comm_fault, e_comm, "communication fault")
            `CHK(status_byte, {6'h00, e_comm, e_flt}, "status byte")
            `CHK(fault_alert_output_n, !(e_comm || e_flt), "alert level")
            `CHK(cfg_err, e_err, "address error")
            `CHK(cfg_err2, e2_err, "fixed strap error")
            if (!e_err) `CHK(bus_addr, e_addr, "bus address")
            if (!e2_err) `CHK(bus_addr2, e2_addr, "fixed strap address")
        end

    // Hang guard
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    // Tri-level grid first, then index corners, then random straps
    initial
    begin
        for (cfg = 0; cfg < 24; cfg++)
        begin
            reset <= 1'b1;
            addr_scheme_tri <= (cfg < 9);
            hl = (cfg < 13) ? hl_c[(cfg + 3) % 4] : {$random(seed)} % 45;
            ll = (cfg < 13) ? ll_c[(cfg + 3) % 4] : {$random(seed)} % 256;
            s_lo <= mk((cfg < 9) ? $random(seed) : ll, (cfg < 9) ? cfg % 3 : {$random(seed)} % 3);
            s_hi <= mk((cfg < 9) ? $random(seed) : hl, (cfg < 9) ? cfg / 3 : {$random(seed)} % 3);
            repeat (6) @(posedge mclk);
            reset <= 1'b0;
            repeat (3) @(posedge mclk);
            s_lo <= mk($random(seed), {$random(seed)} % 3); // Late strap moves are ignored
            s_hi <= mk($random(seed), {$random(seed)} % 3);
            for (i = 0; i < 16; i++)
            begin
                a = (i == 11) ? ADDR_PRODUCTION : (i == 12) ? ADDR_ALERT_RESP :
                    (i == 13) ? e_addr ^ 7'h01 : e_addr;
                fault_event <= (i == 5 || i == 14) ? 8'($random(seed)) : 8'h00;
                xfer(a, (i < 11) ? codes[i] : 8'($random(seed)),
                     (i > 5 && i < 10) || 1'($random(seed)));
            end
        end
        end_of_test();
    end
endmodule
